// ---- fsa_pkg.sv ----
// constants, offsets and types of the flash self-access controller
// assumes one core clock at 250 MHz and a 32-bit Avalon-MM slave port
package fsa_pkg;
  // register byte offsets on the slave port
  localparam logic [4:0] OFS_ADDR_LO = 5'h00;
  localparam logic [4:0] OFS_ADDR_HI = 5'h04;
  localparam logic [4:0] OFS_DATA_LO = 5'h08;
  localparam logic [4:0] OFS_DATA_HI = 5'h0c;
  localparam logic [4:0] OFS_CTRL    = 5'h10;
  localparam logic [4:0] OFS_KEY     = 5'h14;
  // flash_control bit positions
  localparam int CB_RD        = 0;  // read_go_bit
  localparam int CB_WR        = 1;  // program_go_bit
  localparam int CB_PROG_EN   = 2;  // program_enable
  localparam int CB_ERR       = 3;  // interrupted_program_error
  localparam int CB_FREE      = 4;  // row_erase_select
  localparam int CB_LOAD_ONLY = 5;  // latch_load_only
  localparam int CB_CFG_SEL   = 6;  // config_space_select
  localparam int CB_PGD       = 7;  // program_space_select
  // widths of the word and address pieces
  localparam int HI_W  = 6;
  localparam int LO_W  = 8;
  localparam int WORD_W = 14;
  localparam int IDX_W = 5;
  // unlock key values
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // erased flash word and write latch reset value
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam logic [4:0]  LAST_IDX    = 5'h1f;
  // setup cycles before the stall begins
  localparam logic [1:0] SETUP_LAST = 2'h1;
  // erase / program time
  localparam int OP_TIME_NS   = 2000000;
  localparam int CLK_NS       = 4;
  localparam int OP_CYCLES    = OP_TIME_NS / CLK_NS;
  // unlock sequence progress
  typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_ARMED} key_type;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_LOAD, ST_SETUP, ST_WALK, ST_WAIT
  } state_type;
endpackage

// ---- fsa_op_timer.sv ----
// holds the erase / program time as a down counter
// assumes start is a single-cycle pulse from the sequencer
`timescale 1ns/1ps
module fsa_op_timer #(
  parameter int CYCLES = 500000
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  output logic      o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;   // cycles left
  logic          run_q;   // timing in progress

  // done on the last counted cycle
  assign o_done = run_q && (cnt_q == '0);

  // count down, one clock per step
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (i_start) begin
      cnt_q <= LOAD;
      run_q <= 1'b1;
    end else if (o_done) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ---- fsa_flash_array.sv ----
// program flash cell array: one write port, registered read port
// assumes the sequencer never writes and reads the same word at once
`timescale 1ns/1ps
module fsa_flash_array #(
  parameter int AW = 14,
  parameter int DW = 14
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];  // cell contents

  // write or read one word per cycle
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
    o_rdata <= mem_q[i_addr];
  end
endmodule

// ---- fsa_top.sv ----
// flash self-access controller: registers, unlock, read/erase/program
// assumes the cpu honours O_CPU_STALL and O_SLOT_SKIP, one instr/clock
// Function
// - fetch uses second cycle, that instruction skipped
// - read word held in data pair
// - reads ignore code protection
// - erase is always a whole row
// - row_erase_select clears when erase done
// - two setup cycles, then cpu stalls ~2ms
// - programming never erases automatically
// - at most 32 words, never crossing block
// - latches reset to 3fff after programming
// - latch_load_only set: only load a latch
// - latch_load_only clear: load last, program block
// - whole latch block is programmed
// - no stall on latch loads, stall on program
// - go bits self-clear when operation ends
// - program go refused unless program_enable set
// - unlock_key_port reads zero
// - reset during a write sets error flag
`timescale 1ns/1ps
module fsa_top
  import fsa_pkg::*;
#(
  parameter int OP_CYCLES_P = OP_CYCLES
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_POR_RST,
  input  wire logic [4:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic      [31:0] O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  output logic             O_CPU_STALL,
  output logic             O_SLOT_SKIP
);
  // software visible state
  logic [LO_W-1:0] addr_lo_q;   // address_low
  logic [HI_W-1:0] addr_hi_q;   // address_high
  logic [LO_W-1:0] dat_lo_q;    // data_low
  logic [HI_W-1:0] dat_hi_q;    // data_high
  logic            rd_q;        // read_go_bit
  logic            wr_q;        // program_go_bit
  logic            prog_en_q;   // program_enable
  logic            err_q;       // interrupted_program_error
  logic            free_q;      // row_erase_select
  logic            load_only_q; // latch_load_only
  logic            cfg_sel_q;   // config_space_select
  logic            pgd_q;       // program_space_select
  key_type         key_q;       // unlock progress
  // sequencer
  state_type       state_q;     // current step
  logic [1:0]      setup_q;     // setup cycle count
  logic [IDX_W-1:0] idx_q;      // walk index inside block
  logic            active_q;    // write underway, survives I_RST
  logic [WORD_W-1:0] latch_q [0:(1<<IDX_W)-1];  // write latches
  // bus
  logic            ack_q;       // second cycle of an access

  // bus decode
  wire acc      = I_AVS_READ | I_AVS_WRITE;
  wire wr_fire  = I_AVS_WRITE & ack_q & I_AVS_BYTEENABLE[0];
  wire sel_alo  = I_AVS_ADDRESS == OFS_ADDR_LO;
  wire sel_ahi  = I_AVS_ADDRESS == OFS_ADDR_HI;
  wire sel_dlo  = I_AVS_ADDRESS == OFS_DATA_LO;
  wire sel_dhi  = I_AVS_ADDRESS == OFS_DATA_HI;
  wire sel_ctl  = I_AVS_ADDRESS == OFS_CTRL;
  wire sel_key  = I_AVS_ADDRESS == OFS_KEY;
  wire [7:0] wd = I_AVS_WRITEDATA[7:0];
  wire idle     = state_q == ST_IDLE;
  wire ctl_wr   = wr_fire & sel_ctl & idle;

  // one wait cycle on every access
  assign O_AVS_WAITREQUEST = acc & ~ack_q;

  // flash_control as read back
  wire [7:0] ctrl_word;
  assign ctrl_word[CB_RD]   = rd_q;
  assign ctrl_word[CB_WR]   = wr_q;
  assign ctrl_word[CB_PROG_EN]   = prog_en_q;
  assign ctrl_word[CB_ERR]       = err_q;
  assign ctrl_word[CB_FREE]      = free_q;
  assign ctrl_word[CB_LOAD_ONLY] = load_only_q;
  assign ctrl_word[CB_CFG_SEL]   = cfg_sel_q;
  assign ctrl_word[CB_PGD]  = pgd_q;

  // read mux; key port and unmapped offsets read zero
  wire [7:0] rd_mux = sel_alo ? addr_lo_q :
                      sel_ahi ? {2'h0, addr_hi_q} :
                      sel_dlo ? dat_lo_q :
                      sel_dhi ? {2'h0, dat_hi_q} :
                      sel_ctl ? ctrl_word : 8'h00;

  // start conditions
  wire prog_space = pgd_q & ~cfg_sel_q;
  wire go_rd      = ctl_wr & wd[CB_RD] & prog_space;
  wire go_wr_req  = ctl_wr & wd[CB_WR];
  // key must be armed by the two writes just before
  wire go_pgm     = go_wr_req & prog_en_q & prog_space
                  & (key_q == KEY_ARMED);
  wire setup_end  = (state_q == ST_SETUP) & (setup_q == SETUP_LAST);
  wire latch_only = setup_end & load_only_q & ~free_q;
  wire walk_end   = (state_q == ST_WALK) & (idx_q == LAST_IDX);
  wire op_done;

  // flash array port
  wire [WORD_W-1:0] row_lo  = {addr_hi_q, addr_lo_q};
  wire              walking = state_q == ST_WALK;
  // block base from upper bits, index never leaves the block
  wire [WORD_W-1:0] f_addr  = walking ?
      {row_lo[WORD_W-1:IDX_W], idx_q} : row_lo;
  // erase writes ones, programming writes only latch data
  wire [WORD_W-1:0] f_wdata = free_q ? ERASED_WORD :
                              latch_q[idx_q];
  wire [WORD_W-1:0] f_rdata;

  // cpu handshakes: the fetch slot and the long halt
  assign O_SLOT_SKIP = state_q == ST_FETCH;
  assign O_CPU_STALL = walking | (state_q == ST_WAIT);

  // bus answer pacing and read data capture
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_q          <= 1'b0;
      O_AVS_READDATA <= 32'h0000_0000;
    end else begin
      ack_q <= acc & ~ack_q;
      // captured in the wait cycle, stands through the answer edge
      if (I_AVS_READ & ~ack_q) begin
        O_AVS_READDATA <= {24'h00_0000, rd_mux};
      end
    end
  end

  // address pair, software only
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      addr_lo_q <= 8'h00;
      addr_hi_q <= 6'h00;
    end else if (wr_fire & idle) begin
      if (sel_alo) begin
        addr_lo_q <= wd;
      end
      if (sel_ahi) begin
        addr_hi_q <= wd[HI_W-1:0];
      end
    end
  end

  // data pair; a finished fetch wins over a software write
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      dat_lo_q <= 8'h00;
      dat_hi_q <= 6'h00;
    end else if (state_q == ST_LOAD) begin
      dat_lo_q <= f_rdata[LO_W-1:0];
      dat_hi_q <= f_rdata[WORD_W-1:LO_W];
    end else if (wr_fire & idle) begin
      if (sel_dlo) begin
        dat_lo_q <= wd;
      end
      if (sel_dhi) begin
        dat_hi_q <= wd[HI_W-1:0];
      end
    end
  end

  // control bits; go bits set only by software, cleared here
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      prog_en_q   <= 1'b0;
      free_q      <= 1'b0;
      load_only_q <= 1'b0;
      cfg_sel_q   <= 1'b0;
      pgd_q  <= 1'b0;
    end else begin
      if (ctl_wr) begin
        prog_en_q   <= wd[CB_PROG_EN];
        free_q      <= wd[CB_FREE];
        load_only_q <= wd[CB_LOAD_ONLY];
        cfg_sel_q   <= wd[CB_CFG_SEL];
        pgd_q  <= wd[CB_PGD];
      end
      if (go_rd) begin
        rd_q <= 1'b1;
      end else if (state_q == ST_LOAD) begin
        rd_q <= 1'b0;
      end
      if (go_pgm) begin
        wr_q <= 1'b1;
      end else if (latch_only | op_done) begin
        wr_q <= 1'b0;
      end
      // erase completion shows on row_erase_select
      if (op_done & free_q) begin
        free_q <= 1'b0;
      end
    end
  end

  // unlock tracker; any other write with byte lane 0 enabled breaks the sequence
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      key_q <= KEY_NONE;
    end else if (wr_fire) begin
      if (sel_key && wd == KEY_FIRST) begin
        key_q <= KEY_HALF;
      end else if (sel_key && wd == KEY_SECOND && key_q == KEY_HALF) begin
        key_q <= KEY_ARMED;
      end else begin
        key_q <= KEY_NONE;
      end
    end
  end

  // sequencer: fetch, setup, walk the block, hold the time
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
      setup_q <= 2'h0;
      idx_q   <= 5'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          setup_q <= 2'h0;
          idx_q   <= 5'h00;
          if (go_rd) begin
            state_q <= ST_FETCH;
          end else if (go_pgm) begin
            state_q <= ST_SETUP;
          end
        end
        ST_FETCH: state_q <= ST_LOAD;
        ST_LOAD:  state_q <= ST_IDLE;
        ST_SETUP: begin
          setup_q <= setup_q + 2'h1;
          if (setup_end) begin
            // latch loads return at once, no halt
            state_q <= latch_only ? ST_IDLE : ST_WALK;
          end
        end
        ST_WALK: begin
          idx_q <= idx_q + 5'h01;
          if (walk_end) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (op_done) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // write latches; last word loaded before the program walk
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < (1 << IDX_W); i++) begin
        latch_q[i] <= ERASED_WORD;
      end
    end else if (setup_end & ~free_q) begin
      latch_q[addr_lo_q[IDX_W-1:0]] <=
        {dat_hi_q, dat_lo_q};
    end else if (op_done & ~free_q) begin
      for (int i = 0; i < (1 << IDX_W); i++) begin
        latch_q[i] <= ERASED_WORD;
      end
    end
  end

  // write-underway marker cleared by power-on reset, by completion, or once seen while idle
  always_ff @(posedge I_CORE_CLK or posedge I_POR_RST) begin
    if (I_POR_RST) begin
      active_q <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      if (walking) begin
        active_q <= 1'b1;
      end else if (op_done | (active_q & idle)) begin
        active_q <= 1'b0;
      end
      // marker still up while idle means a reset cut the write
      if (active_q & idle) begin
        err_q <= 1'b1;
      end else if (ctl_wr & ~wd[CB_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end

  // hold timer for erase and programming
  fsa_op_timer #(
    .CYCLES (OP_CYCLES_P)
  ) u_timer (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_start (walk_end),
    .o_done  (op_done)
  );

  // the cell array itself
  fsa_flash_array #(
    .AW (WORD_W),
    .DW (WORD_W)
  ) u_array (
    .i_clk   (I_CORE_CLK),
    .i_we    (walking),
    .i_addr  (f_addr),
    .i_wdata (f_wdata),
    .o_rdata (f_rdata)
  );

  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_walk_start;
    $rose(state_q == ST_WALK);
  endsequence
  sequence s_go_setup;
    go_pgm ##1 (state_q == ST_SETUP);
  endsequence

  a_go_needs_enable: assert property (
    go_wr_req & ~prog_en_q |=> state_q == ST_IDLE)
    else $error("go accepted without program_enable");
  a_key_required: assert property (
    go_wr_req & (key_q != KEY_ARMED) |=> ~wr_q && state_q == ST_IDLE)
    else $error("operation started without unlock key");
  a_read_data_load: assert property (
    state_q == ST_LOAD |=> dat_lo_q == $past(f_rdata[7:0])
                        && dat_hi_q == $past(f_rdata[13:8]))
    else $error("fetched word not in data pair");
  a_read_self_clear: assert property (
    go_rd |=> O_SLOT_SKIP ##1 rd_q ##1 ~rd_q)
    else $error("read go bit not cleared after fetch");
  a_setup_no_stall: assert property (
    s_go_setup |-> ~O_CPU_STALL ##1 ~O_CPU_STALL)
    else $error("cpu stalled during setup cycles");
  a_latch_no_stall: assert property (
    latch_only |=> state_q == ST_IDLE && ~O_CPU_STALL && ~wr_q)
    else $error("latch load stalled or kept go bit");
  a_walk_block_len: assert property (
    s_walk_start |-> ##32 (state_q == ST_WAIT))
    else $error("block walk not exactly 32 words");
  a_erase_all_ones: assert property (
    walking & free_q |-> f_wdata == ERASED_WORD)
    else $error("erase wrote a word other than all ones");
  a_latch_reset: assert property (
    op_done & ~free_q |=> latch_q[0] == ERASED_WORD
                       && latch_q[31] == ERASED_WORD)
    else $error("latches not reset after programming");
  a_key_port_zero: assert property (
    I_AVS_READ & sel_key & ~ack_q |=> O_AVS_READDATA == 32'h0)
    else $error("unlock key port read not zero");
endmodule

// ---- fsa_cpu_model.sv ----
// cpu core stand-in facing the stall and slot-skip outputs
// assumes one instruction slot per core clock, only nops in dropped slots
`timescale 1ns/1ps
module fsa_cpu_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_stall,
  input  wire logic i_skip,
  output int        o_stalls,
  output int        o_skips
);
  // tally halted and dropped slots; the slots after a go are nops
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_stalls <= 0;
      o_skips  <= 0;
    end else begin
      // a halted slot retires nothing
      if (i_stall === 1'b1) begin
        o_stalls <= o_stalls + 1;
      end
      // a dropped slot holds a nop, never a two-cycle instruction
      if (i_skip === 1'b1) begin
        o_skips <= o_skips + 1;
      end
    end
  end
endmodule

// ---- program_flash_self_access_tb.sv ----
// self-checking bench for the flash self-access controller
// assumes the package offsets and a short erase / program time
`timescale 1ns/1ps
module program_flash_self_access_tb;
  import fsa_pkg::*;
  localparam int OPC = 20;       // shortened hold time
  logic        clk;              // core clock
  logic        rst;              // device reset
  logic        por;              // power-on reset
  logic [4:0]  adr;              // slave address
  logic        rd_en;            // read request
  logic        wr_en;            // write request
  logic [31:0] wdat;             // write data
  logic [31:0] rdat;             // read data
  logic        wait_req;         // slave waitrequest
  logic [3:0]  be;               // write byte enables
  logic        stall;            // cpu halted
  logic        skip;             // slot dropped
  int          stalls;           // halted slots so far
  int          skips;            // dropped slots so far
  int          miscompares;      // failed compares
  int          checked;          // compares made
  int          s0;               // halted slots before a go
  logic [31:0] q;                // last read data

  fsa_top #(.OP_CYCLES_P(OPC)) dut_u (
    .I_CORE_CLK       (clk),
    .I_RST            (rst),
    .I_POR_RST        (por),
    .I_AVS_ADDRESS    (adr),
    .I_AVS_READ       (rd_en),
    .I_AVS_WRITE      (wr_en),
    .I_AVS_WRITEDATA  (wdat),
    .I_AVS_BYTEENABLE (be),
    .O_AVS_READDATA   (rdat),
    .O_AVS_WAITREQUEST(wait_req),
    .O_CPU_STALL      (stall),
    .O_SLOT_SKIP      (skip)
  );

  fsa_cpu_model cpu_u (
    .i_clk   (clk),
    .i_rst   (rst),
    .i_stall (stall),
    .i_skip  (skip),
    .o_stalls(stalls),
    .o_skips (skips)
  );

  // free-running 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // verdict and end of run
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one compare, counted
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // one slave access; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk);
    adr   <= a;
    wr_en <= w;
    rd_en <= !w;
    wdat  <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 16);
    q = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    // a slave that never answers ends the run
    if (n >= 16) begin
      miscompares++;
      report_and_stop;
    end
  endtask

  // poll flash_control until a bit drops, bounded
  task automatic wait_clear(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_CTRL, 8'h00);
      n++;
    end while (q[b] !== 1'b0 && n < 100);
    if (n >= 100) begin
      miscompares++;
      report_and_stop;
    end
  endtask

  // select bits, key pair, go; brk slips a write into the key
  task automatic do_op(input logic [7:0] c, input logic brk);
    bus(1'b1, OFS_CTRL, c);
    bus(1'b1, OFS_KEY, KEY_FIRST);
    if (brk) begin
      bus(1'b1, OFS_DATA_LO, 8'h00);
    end
    bus(1'b1, OFS_KEY, KEY_SECOND);
    s0 = stalls;
    bus(1'b1, OFS_CTRL, c | 8'h02);
    wait_clear(CB_WR);
  endtask

  // read one flash word and compare the data pair
  task automatic fread(input logic [7:0] hi, input logic [7:0] lo,
                       input logic [13:0] e);
    int k;
    k = skips;
    bus(1'b1, OFS_ADDR_HI, hi);
    bus(1'b1, OFS_ADDR_LO, lo);
    bus(1'b1, OFS_CTRL, 8'h81);
    wait_clear(CB_RD);
    bus(1'b0, OFS_DATA_LO, 8'h00);
    chk("data_low", {24'h0, e[7:0]}, q);
    bus(1'b0, OFS_DATA_HI, 8'h00);
    chk("data_high", {26'h0, e[13:8]}, q);
    chk("dropped slots", k + 1, skips);
  endtask

  // load address and data pairs in one go
  task automatic load(input logic [7:0] hi, input logic [7:0] lo,
                      input logic [13:0] d);
    bus(1'b1, OFS_ADDR_HI, hi);
    bus(1'b1, OFS_ADDR_LO, lo);
    bus(1'b1, OFS_DATA_LO, d[7:0]);
    bus(1'b1, OFS_DATA_HI, {2'h0, d[13:8]});
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    por = 1'b1;
    adr = 5'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdat = 32'h0;
    be = 4'hf;
    miscompares = 0;
    checked = 0;
    s0 = 0;
    q = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    // reset values, key port, unmapped place
    bus(1'b0, OFS_CTRL, 8'h00);
    chk("control at reset", 32'h0, q);
    bus(1'b1, OFS_KEY, KEY_FIRST);
    bus(1'b0, OFS_KEY, 8'h00);
    chk("key port", 32'h0, q);
    bus(1'b0, 5'h18, 8'h00);
    chk("unmapped", 32'h0, q);
    // a write with byte lane 0 off must be dropped
    be <= 4'h0;
    bus(1'b1, OFS_ADDR_LO, 8'h5a);
    be <= 4'hf;
    bus(1'b0, OFS_ADDR_LO, 8'h00);
    chk("masked write", 32'h0, q);
    // row erase of row 8
    load(8'h01, 8'h00, 14'h0000);
    do_op(8'h94, 1'b0);
    chk("erase stall", OPC + 32, stalls - s0);
    wait_clear(CB_FREE);
    chk("control after erase", 32'h84, q);
    fread(8'h01, 8'h07, ERASED_WORD);
    // read start refused while config space is selected
    bus(1'b1, OFS_CTRL, 8'hc0);
    bus(1'b1, OFS_CTRL, 8'hc1);
    bus(1'b0, OFS_CTRL, 8'h00);
    chk("config space read refused", 32'hc0, q);
    // go without enable, then a broken key
    do_op(8'h90, 1'b0);
    chk("refused control", 32'h90, q);
    chk("refused stall", 0, stalls - s0);
    do_op(8'h94, 1'b1);
    chk("broken key stall", 0, stalls - s0);
    // latch load only, then final latch and program
    load(8'h01, 8'h03, 14'h1234);
    do_op(8'ha4, 1'b0);
    chk("latch load stall", 0, stalls - s0);
    fread(8'h01, 8'h03, ERASED_WORD);
    load(8'h01, 8'h05, 14'h0abc);
    do_op(8'h84, 1'b0);
    chk("program stall", OPC + 32, stalls - s0);
    fread(8'h01, 8'h03, 14'h1234);
    fread(8'h01, 8'h05, 14'h0abc);
    fread(8'h01, 8'h04, ERASED_WORD);
    // latches back at erased value after programming
    load(8'h02, 8'h00, 14'h0000);
    do_op(8'h94, 1'b0);
    load(8'h02, 8'h1f, 14'h0001);
    do_op(8'h84, 1'b0);
    fread(8'h02, 8'h1f, 14'h0001);
    fread(8'h02, 8'h03, ERASED_WORD);
    // reset in mid erase leaves the error flag
    load(8'h01, 8'h00, 14'h0000);
    bus(1'b1, OFS_CTRL, 8'h94);
    bus(1'b1, OFS_KEY, KEY_FIRST);
    bus(1'b1, OFS_KEY, KEY_SECOND);
    bus(1'b1, OFS_CTRL, 8'h96);
    repeat (10) @(posedge clk);
    chk("stall in erase", 32'h1, {31'h0, stall});
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b0, OFS_CTRL, 8'h00);
    chk("error flag", 32'h08, q);
    bus(1'b1, OFS_CTRL, 8'h00);
    bus(1'b0, OFS_CTRL, 8'h00);
    chk("error cleared", 32'h0, q);
    report_and_stop;
  end
endmodule
